//--- acpf_pkg.sv
`default_nettype none
package acpf_pkg;

  // register addresses carried in the command word
  localparam logic [6:0] ADDR_CONV     = 7'h00;
  localparam logic [6:0] ADDR_PWR_DN   = 7'h02;
  localparam logic [6:0] ADDR_FEATURE  = 7'h03;

  // command word layout
  localparam int CMD_BITS      = 16;
  localparam int CMD_ADDR_LSB  = 9;
  localparam int CMD_WR_BIT    = 8;

  // feature register field positions
  localparam int FEAT_DEV_LSB  = 6;
  localparam int FEAT_ALERT    = 4;
  localparam int FEAT_FMT_LSB  = 0;

  // reset values
  localparam logic [7:0] PWR_DN_RST   = 8'h00;
  localparam logic [7:0] FEATURE_RST  = 8'h00;

  // output frame
  localparam int OUT_BITS       = 25;
  localparam int OUT_START_FALL = 16;
  localparam logic [15:0] INVALID_RESULT = 16'hFFFF;

  typedef enum logic [2:0] {
    FMT_RESULT   = 3'h0,
    FMT_CHAN     = 3'h1,
    FMT_CHAN_DEV = 3'h2,
    FMT_FULL     = 3'h3
  } acpf_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_DATA = 2'b10
  } acpf_state_t;

  typedef struct packed {
    logic [1:0] chain_id;
    logic       alert_en;
    logic [2:0] fmt;
  } acpf_feature_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } acpf_link_t;

endpackage
`default_nettype wire

//--- acpf_core.sv
// Behaviour
// - power-down bit: front-end off, skipped by scan
// - bit clear (reset): powered, scan allowed
// - four-channel: writes to channels 4-7 ignored
// - four-channel: absent bits read as ones
// - feature bits 7-6: chain id, reset 00
// - feature bit 4: alert enable, reset off
// - feature bits 2-0: output format, reset 000
// - output starts at sixteenth sclk falling edge
// - frame bits 24-9: result, msb first
// - format 000: result then low bits
// - formats 001-011: bits 8-5 channel address
// - formats 010,011: bits 4-3 chain id
// - format 011: bits 2-0 range lsbs
// - auto scan steps ascending through allowed channels
// - all channels off: result marked invalid
`timescale 1ns/1ps
`default_nettype none
module acpf_core #(
  parameter int NUM_CH = 8
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // serial link
  input  wire acpf_pkg::acpf_link_t  link,
  output logic                       sdo,
  // conversion core side
  input  wire logic [15:0]           conv_result,
  input  wire logic [7:0][2:0]       range_lsb,
  input  wire logic [7:0]            scan_enable,
  input  wire logic                  auto_scan,
  input  wire logic [2:0]            manual_channel,
  output logic [2:0]                 scan_channel,
  output logic                       conv_start,
  output logic                       data_invalid,
  // configuration outputs
  output logic [7:0]                 front_end_off,
  output acpf_pkg::acpf_feature_t    feature
);

  if (NUM_CH != 4 && NUM_CH != 8) begin : g_bad_num_ch
    $error("acpf_core: NUM_CH must be 4 or 8");
  end

  localparam logic [7:0] PRESENT = 8'((1 << NUM_CH) - 1);

  // link synchronisers
  logic [2:0] link_m_q;
  logic [2:0] link_s_q;
  logic       sclk_p_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      link_m_q <= 3'h4;
      link_s_q <= 3'h4;
      sclk_p_q <= 1'b0;
    end else begin
      link_m_q <= link;
      link_s_q <= link_m_q;
      sclk_p_q <= link_s_q[1];
    end
  end

  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_rise;
  logic sclk_fall;

  assign cs_n_s    = link_s_q[2];
  assign sclk_s    = link_s_q[1];
  assign sdi_s     = link_s_q[0];
  assign sclk_rise = sclk_s & ~sclk_p_q;
  assign sclk_fall = ~sclk_s & sclk_p_q;

  // frame and register state
  acpf_pkg::acpf_state_t   state_q, state_d;
  logic [4:0]              fall_cnt_q, fall_cnt_d;
  logic [15:0]             cmd_q, cmd_d;
  logic [acpf_pkg::OUT_BITS-1:0] out_q, out_d;
  logic [7:0]              pwr_dn_q, pwr_dn_d;
  acpf_pkg::acpf_feature_t feat_q, feat_d;
  logic [2:0]              chan_q, chan_d;
  logic [2:0]              frame_chan_q, frame_chan_d;
  logic [15:0]             res_q, res_d;
  logic                    start_q, start_d;

  logic [7:0] allow;
  logic       all_off;
  logic       frame_start;
  logic       decode;
  logic [6:0] cmd_addr;
  logic       cmd_wr;
  logic [7:0] cmd_data;
  logic [7:0] rd_val;
  logic [3:0] chan_addr;

  assign allow       = scan_enable & ~pwr_dn_q & PRESENT;
  // all-off detect
  // invalid when all off
  assign all_off     = (pwr_dn_q & PRESENT) == PRESENT;
  assign frame_start = (state_q == acpf_pkg::ST_IDLE) && !cs_n_s;
  assign decode      = (state_q == acpf_pkg::ST_CMD) && sclk_fall
                       && fall_cnt_q == 5'(acpf_pkg::OUT_START_FALL - 1);
  assign cmd_addr    = cmd_q[acpf_pkg::CMD_BITS-1:acpf_pkg::CMD_ADDR_LSB];
  assign cmd_wr      = cmd_q[acpf_pkg::CMD_WR_BIT];
  assign cmd_data    = cmd_q[7:0];
  assign chan_addr   = {1'b0, frame_chan_q};

  // next allowed channel above cur, wrapping; channel 0 if none
  function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [7:0] ok);
    logic [2:0] r;
    logic       found;
    logic [2:0] idx;
    r     = 3'h0;
    found = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      idx = 3'(int'(cur) + k);
      if (!found && ok[idx]) begin
        r     = idx;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  always_comb begin
    state_d      = state_q;
    fall_cnt_d   = fall_cnt_q;
    cmd_d        = cmd_q;
    out_d        = out_q;
    pwr_dn_d     = pwr_dn_q;
    feat_d       = feat_q;
    chan_d       = chan_q;
    frame_chan_d = frame_chan_q;
    res_d        = res_q;
    start_d      = 1'b0;
    rd_val       = 8'h00;
    unique case (state_q)
      acpf_pkg::ST_IDLE: begin
        out_d = '0;
        if (!cs_n_s) begin
          state_d      = acpf_pkg::ST_CMD;
          fall_cnt_d   = 5'h00;
          start_d      = 1'b1;
          frame_chan_d = chan_q;
          res_d        = all_off ? acpf_pkg::INVALID_RESULT : conv_result;
          if (auto_scan) begin
            chan_d = next_chan(chan_q, allow);
          end else begin
            chan_d = manual_channel;
          end
        end
      end
      acpf_pkg::ST_CMD: begin
        if (cs_n_s) begin
          state_d = acpf_pkg::ST_IDLE;
        end else begin
          if (sclk_rise) begin
            cmd_d = {cmd_q[14:0], sdi_s};
          end
          if (sclk_fall) begin
            fall_cnt_d = fall_cnt_q + 5'h01;
          end
          if (decode) begin
            state_d = acpf_pkg::ST_DATA;
            if (cmd_addr == acpf_pkg::ADDR_PWR_DN) begin
              if (cmd_wr) begin
                pwr_dn_d = cmd_data & PRESENT;
              end
              rd_val = pwr_dn_d | ~PRESENT;
              out_d  = {rd_val, 17'h00000};
            end else if (cmd_addr == acpf_pkg::ADDR_FEATURE) begin
              if (cmd_wr) begin
                feat_d.chain_id = cmd_data[acpf_pkg::FEAT_DEV_LSB +: 2];
                feat_d.alert_en = cmd_data[acpf_pkg::FEAT_ALERT];
                feat_d.fmt      = cmd_data[acpf_pkg::FEAT_FMT_LSB +: 3];
              end
              rd_val = {feat_d.chain_id, 1'b0, feat_d.alert_en, 1'b0, feat_d.fmt};
              out_d  = {rd_val, 17'h00000};
            end else if (cmd_addr == acpf_pkg::ADDR_CONV) begin
              unique case (feat_q.fmt)
                acpf_pkg::FMT_CHAN: out_d = {res_q, chan_addr, 5'h00};
                acpf_pkg::FMT_CHAN_DEV: out_d = {res_q, chan_addr, feat_q.chain_id, 3'h0};
                acpf_pkg::FMT_FULL: out_d = {res_q, chan_addr, feat_q.chain_id,
                                             range_lsb[frame_chan_q]};
                default: out_d = {res_q, 9'h000};
              endcase
            end else begin
              out_d = '0;
            end
          end
        end
      end
      acpf_pkg::ST_DATA: begin
        if (cs_n_s) begin
          state_d = acpf_pkg::ST_IDLE;
          out_d   = '0;
        end else if (sclk_fall) begin
          out_d = {out_q[acpf_pkg::OUT_BITS-2:0], 1'b0};
        end
      end
      default: begin
        state_d = acpf_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q      <= acpf_pkg::ST_IDLE;
      fall_cnt_q   <= 5'h00;
      cmd_q        <= 16'h0000;
      out_q        <= '0;
      pwr_dn_q     <= acpf_pkg::PWR_DN_RST;
      feat_q       <= acpf_pkg::acpf_feature_t'({acpf_pkg::FEATURE_RST[7:6],
                                                 acpf_pkg::FEATURE_RST[4],
                                                 acpf_pkg::FEATURE_RST[2:0]});
      chan_q       <= 3'h0;
      frame_chan_q <= 3'h0;
      res_q        <= 16'h0000;
      start_q      <= 1'b0;
    end else begin
      state_q      <= state_d;
      fall_cnt_q   <= fall_cnt_d;
      cmd_q        <= cmd_d;
      out_q        <= out_d;
      pwr_dn_q     <= pwr_dn_d;
      feat_q       <= feat_d;
      chan_q       <= chan_d;
      frame_chan_q <= frame_chan_d;
      res_q        <= res_d;
      start_q      <= start_d;
    end
  end

  assign sdo           = out_q[acpf_pkg::OUT_BITS-1];
  assign front_end_off = pwr_dn_q;
  assign feature       = feat_q;
  assign scan_channel  = chan_q;
  assign conv_start    = start_q;
  assign data_invalid  = all_off;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_absent_pd_zero: assert property (NUM_CH == 4 |-> front_end_off[7:4] == 4'h0)
    else $error("absent channel power-down bit set");
  a_absent_rd_ones: assert property (decode && cmd_addr == acpf_pkg::ADDR_PWR_DN && NUM_CH == 4
    |=> out_q[24:21] == 4'hF) else $error("absent channel bits not read as ones");
  a_scan_skips_off: assert property (frame_start && auto_scan && (|allow)
    |-> allow[chan_d]) else $error("scan picked excluded channel");
  a_scan_ascend: assert property (frame_start && auto_scan && allow == PRESENT
    |=> chan_q == 3'((int'($past(chan_q)) + 1) % NUM_CH)) else $error("scan not ascending");
  a_feature_write: assert property (decode && cmd_addr == acpf_pkg::ADDR_FEATURE && cmd_wr
    |=> feat_q == {$past(cmd_data[7:6]), $past(cmd_data[4]), $past(cmd_data[2:0])})
    else $error("feature write not stored");
  a_reserved_zero: assert property (decode && cmd_addr == acpf_pkg::ADDR_FEATURE
    |=> out_q[22] == 1'b0 && out_q[20] == 1'b0) else $error("reserved feature bits not zero");
  a_out_start: assert property (decode |=> state_q == acpf_pkg::ST_DATA ##0
    fall_cnt_q == 5'(acpf_pkg::OUT_START_FALL)) else $error("output not started on 16th edge");
  a_result_bits: assert property (decode && cmd_addr == acpf_pkg::ADDR_CONV
    |=> out_q[24:9] == $past(res_q)) else $error("result bits wrong");
  a_fmt_plain: assert property (decode && cmd_addr == acpf_pkg::ADDR_CONV
    && (feat_q.fmt == 3'h0 || feat_q.fmt[2]) |=> out_q[8:0] == 9'h000)
    else $error("plain format tail not low");
  a_fmt_chan: assert property (decode && cmd_addr == acpf_pkg::ADDR_CONV
    && feat_q.fmt inside {3'h1, 3'h2, 3'h3} |=> out_q[8:5] == {1'b0, frame_chan_q})
    else $error("channel address bits wrong");
  a_fmt_dev: assert property (decode && cmd_addr == acpf_pkg::ADDR_CONV
    && feat_q.fmt == 3'h2 |=> out_q[4:0] == {feat_q.chain_id, 3'h0})
    else $error("device id bits wrong");
  a_fmt_range: assert property (decode && cmd_addr == acpf_pkg::ADDR_CONV
    && feat_q.fmt == 3'h3 |=> out_q[2:0] == $past(range_lsb[frame_chan_q]))
    else $error("range bits wrong");
  a_all_off_inv: assert property (frame_start && all_off
    |=> res_q == acpf_pkg::INVALID_RESULT) else $error("all-off result not invalid");

  c_conv_frame: cover property (decode && cmd_addr == acpf_pkg::ADDR_CONV && feat_q.fmt == 3'h3);
  c_pd_write: cover property (decode && cmd_addr == acpf_pkg::ADDR_PWR_DN && cmd_wr);
  c_feat_read: cover property (decode && cmd_addr == acpf_pkg::ADDR_FEATURE && !cmd_wr);
  c_scan_wrap: cover property (frame_start && auto_scan && chan_d < chan_q);

endmodule
`default_nettype wire

//--- acpf_host.sv
`timescale 1ns/1ps
`default_nettype none
module acpf_host (
  // clock
  input  wire logic                 core_clk,
  // link to device
  output var acpf_pkg::acpf_link_t  link,
  input  wire logic [1:0]           sdo_pair
);
  initial link = 3'h4;

  // one frame of n sclk cycles, sdo captured on rising edges after the command
  task automatic xfer(input logic [15:0] cmd, input int n,
                      output logic [24:0] rx0, output logic [24:0] rx1);
    rx0 = 25'h0000000;
    rx1 = 25'h0000000;
    link.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      link.sdi <= (i < 16) ? cmd[15-i] : 1'b0;
      repeat (4) @(posedge core_clk);
      link.sclk <= 1'b1;
      if (i >= 16) begin
        rx0 = {rx0[23:0], sdo_pair[0]};
        rx1 = {rx1[23:0], sdo_pair[1]};
      end
      repeat (4) @(posedge core_clk);
      link.sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    link.cs_n <= 1'b1;
    link.sdi  <= ~link.sdi;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    logic [24:0] d0;
    logic [24:0] d1;
    if (addr == acpf_pkg::ADDR_FEATURE) data = data & 8'hD7;
    xfer({addr, 1'b1, data}, 16, d0, d1);
  endtask
endmodule
`default_nettype wire

//--- tb_adc_channel_power_and_output_format.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_channel_power_and_output_format;
  typedef struct packed {
    logic [7:0] feat;
    logic [2:0] chan;
    logic [2:0] rng;
    logic [8:0] tail;
  } acpf_row_t;

  logic                    core_clk;
  logic                    reset;
  acpf_pkg::acpf_link_t    link;
  wire logic [1:0]         sdo_pair;
  logic [2:0]              chan8;
  logic                    start8;
  int                      starts = 0;
  int                      snap;
  logic [15:0]             conv_result;
  logic [7:0][2:0]         range_lsb;
  logic [7:0]              scan_enable;
  logic                    auto_scan;
  logic [2:0]              manual_channel;
  logic [7:0]              off8;
  logic [7:0]              off4;
  acpf_pkg::acpf_feature_t feat8;
  acpf_pkg::acpf_feature_t feat4;
  logic                    inv8;
  logic                    inv4;
  logic [24:0]             rx0;
  logic [24:0]             rx1;
  int                      errors;
  int                      compares;
  int                      k;
  logic [2:0]              seq [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
  acpf_row_t               rows [9] = '{
    '{8'hD0, 3'h5, 3'h7, 9'h000}, '{8'h81, 3'h6, 3'h5, 9'h0C0},
    '{8'h42, 3'h3, 3'h6, 9'h068}, '{8'hD3, 3'h7, 3'h5, 9'h0FD},
    '{8'h84, 3'h1, 3'h7, 9'h000}, '{8'h15, 3'h2, 3'h3, 9'h000},
    '{8'h46, 3'h4, 3'h1, 9'h000}, '{8'hC7, 3'h0, 3'h6, 9'h000},
    '{8'h03, 3'h0, 3'h2, 9'h002}};

  acpf_host u_acpf_host (.core_clk(core_clk), .link(link), .sdo_pair(sdo_pair));

  acpf_core #(.NUM_CH(8)) u_acpf_core (
    .core_clk(core_clk), .reset(reset), .link(link), .sdo(sdo_pair[0]),
    .conv_result(conv_result), .range_lsb(range_lsb), .scan_enable(scan_enable),
    .auto_scan(auto_scan), .manual_channel(manual_channel), .scan_channel(chan8),
    .conv_start(start8), .data_invalid(inv8), .front_end_off(off8), .feature(feat8));

  always @(posedge core_clk) begin
    if (start8) begin
      starts <= starts + 1;
    end
  end

  acpf_core #(.NUM_CH(4)) u_acpf_core_n4 (
    .core_clk(core_clk), .reset(reset), .link(link), .sdo(sdo_pair[1]),
    .conv_result(conv_result), .range_lsb(range_lsb), .scan_enable(scan_enable),
    .auto_scan(auto_scan), .manual_channel(manual_channel), .scan_channel(),
    .conv_start(), .data_invalid(inv4), .front_end_off(off4), .feature(feat4));

  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check_frame(input string what, input logic [24:0] exp, input logic [24:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [6:0] addr);
    u_acpf_host.xfer({addr, 1'b0, 8'h00}, 41, rx0, rx1);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    compares = 0;
    reset = 1'b1;
    conv_result = 16'h0000;
    range_lsb = '0;
    scan_enable = 8'hFF;
    auto_scan = 1'b0;
    manual_channel = 3'h0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    check_byte("power port", 8'h00, off8);
    check_byte("feature port", 8'h00, {2'h0, feat8});
    rd(acpf_pkg::ADDR_FEATURE);
    check_frame("feature read", 25'h0000000, rx0);
    rd(acpf_pkg::ADDR_PWR_DN);
    check_frame("power read", 25'h0000000, rx0);
    check_frame("power read 4ch", {8'hF0, 17'h00000}, rx1);
    foreach (rows[i]) begin
      manual_channel <= rows[i].chan;
      conv_result <= {rows[i].feat, 8'h3C};
      for (int c = 0; c < 8; c++) range_lsb[c] <= (c == rows[i].chan) ? rows[i].rng : ~rows[i].rng;
      u_acpf_host.wr(acpf_pkg::ADDR_FEATURE, rows[i].feat);
      check_byte("feature port", {2'h0, rows[i].feat[7:6], rows[i].feat[4], rows[i].feat[2:0]},
                 {2'h0, feat8});
      rd(acpf_pkg::ADDR_FEATURE);
      check_frame("feature read", {rows[i].feat, 17'h00000}, rx0);
      rd(acpf_pkg::ADDR_CONV);
      check_frame("conversion frame", {rows[i].feat, 8'h3C, rows[i].tail}, rx0);
    end
    u_acpf_host.xfer({acpf_pkg::ADDR_FEATURE, 1'b1, 8'h10}, 10, rx0, rx1);
    check_byte("aborted write", 8'h03, {2'h0, feat8});
    u_acpf_host.wr(acpf_pkg::ADDR_PWR_DN, 8'hFF);
    check_byte("power port", 8'hFF, off8);
    check_byte("power port 4ch", 8'h0F, off4);
    check_byte("invalid flags", 8'h03, {6'h00, inv4, inv8});
    rd(acpf_pkg::ADDR_CONV);
    check_frame("all off frame", {16'hFFFF, 9'h002}, rx0);
    rd(acpf_pkg::ADDR_PWR_DN);
    check_frame("power read", {8'hFF, 17'h00000}, rx0);
    check_frame("power read 4ch", {8'hFF, 17'h00000}, rx1);
    u_acpf_host.wr(acpf_pkg::ADDR_PWR_DN, 8'h22);
    scan_enable <= 8'hF7;
    auto_scan <= 1'b1;
    check_byte("power port", 8'h22, off8);
    rd(acpf_pkg::ADDR_CONV);
    k = 0;
    for (int j = 0; j < 5; j++) if (seq[j] == rx0[7:5]) k = j;
    for (int j = 0; j < 6; j++) begin
      rd(acpf_pkg::ADDR_CONV);
      k = (k + 1) % 5;
      check_byte("scan channel", {5'h00, seq[k]}, {4'h0, rx0[8:5]});
      check_byte("scan channel 4ch", {5'h00, (((j % 2) == 0) ? 3'h2 : 3'h0)}, {4'h0, rx1[8:5]});
    end
    scan_enable <= 8'hFF;
    u_acpf_host.wr(acpf_pkg::ADDR_PWR_DN, 8'h00);
    for (int j = 0; j < 3; j++) begin
      snap = starts;
      rd(acpf_pkg::ADDR_CONV);
      check_byte("scan step", {5'h00, 3'(6 + j)}, {4'h0, rx0[8:5]});
      check_byte("scan step 4ch", {6'h00, 2'(3 + j)}, {4'h0, rx1[8:5]});
      check_byte("scan channel port", {5'h00, 3'(7 + j)}, {5'h00, chan8});
      check_byte("start pulses", 8'h01, 8'(starts - snap));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
